// [adcc_top.sv]
// Converter control and trigger block: registers on AHB-Lite, start logic, interrupt.
// Assumes a single 100 MHz core clock, trigger and RC tick as one-cycle pulses in it.
//
// The AHB-Lite slave port was decided locally.
`timescale 1ns/1ps
`include "adcc_defines.svh"

module adcc_top (
	input  wire logic        i_mclk,
	input  wire logic        i_rst,
	input  wire logic        i_warm_rst,
	// AHB-Lite slave
	input  wire logic        i_hsel,
	input  wire logic [31:0] i_haddr,
	input  wire logic [1:0]  i_htrans,
	input  wire logic        i_hwrite,
	input  wire logic [2:0]  i_hsize,
	input  wire logic [31:0] i_hwdata,
	input  wire logic        i_hready,
	output logic             o_hreadyout,
	output logic             o_hresp,
	output logic [31:0]      o_hrdata,
	// Capture/compare unit and timer
	input  wire logic [3:0]  i_compare_unit_mode_field,
	input  wire logic        i_special_event_trigger,
	output logic             o_timer_clear,
	// Analog conversion core
	input  wire logic        i_cmp_high,
	input  wire logic        i_rc_half_tick,
	output logic [7:0]       o_trial_code,
	output logic             o_hold_sample,
	output logic [2:0]       o_input_channel_select,
	output logic             o_converter_power,
	output logic [2:0]       o_pin_analog_config,
	// Port A
	input  wire logic [5:0]  i_port_a_pin_levels,
	output logic [5:0]       o_port_a_direction,
	output logic [5:0]       o_port_a_out,
	// Interrupt
	output logic             o_irq
);
	import adcc_pkg::*;

	logic [7:0]  ctrl_q;
	logic [2:0]  pin_cfg_q;
	logic [5:0]  dir_q;
	logic [5:0]  port_out_q;
	logic        cc_flag_q;
	logic        cc_enable_q;
	logic [1:0]  core_irq_q;
	logic        pend_q;
	logic        wr_q;
	logic        mapped_q;
	logic [7:0]  idx_q;
	logic        acc;
	logic        wr_en;
	logic        rd_en;
	logic [7:0]  wdata;
	logic [7:0]  rdata;
	logic        go_q;
	logic        power_q;
	logic        trig_mode;
	logic        trig_ok;
	logic        sar_busy;
	logic        sar_done;
	logic        sar_start;
	logic        sar_abort;
	logic        half_tick;
	logic [7:0]  result;

	// Decode of one register index against the captured address
	function automatic logic hit(input logic [7:0] idx, input logic [7:0] reg_idx);
		hit = idx == reg_idx;
	endfunction

	// Pins configured as analog inputs read as low on the port
	function automatic logic [5:0] analog_mask(input logic [2:0] cfg);
		unique case (cfg)
			3'b000, 3'b001, 3'b010, 3'b011: analog_mask = 6'h2f;
			3'b100, 3'b101:                 analog_mask = 6'h0b;
			3'b110, 3'b111:                 analog_mask = 6'h00;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Bus slave: one wait state, then registered read data
	assign acc   = i_hsel && i_htrans[1] && i_hready;
	assign wr_en = pend_q && wr_q && mapped_q;
	assign rd_en = pend_q && !wr_q && mapped_q;
	assign wdata = i_hwdata[7:0];

	// Address phase capture
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			pend_q   <= 1'b0;
			wr_q     <= 1'b0;
			mapped_q <= 1'b0;
			idx_q    <= 8'h00;
		end else begin
			pend_q   <= acc;
			if (acc) begin
				wr_q     <= i_hwrite;
				mapped_q <= (i_haddr[31:10] == 22'h000000) && (i_haddr[1:0] == 2'b00);
				idx_q    <= i_haddr[9:2];
			end
		end
	end

	// Ready low for the cycle after an accepted address phase
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			o_hreadyout <= 1'b1;
			o_hresp     <= 1'b0;
		end else begin
			o_hreadyout <= !acc;
			o_hresp     <= 1'b0;
		end
	end

	// Read multiplexer; unmapped and unimplemented bits read zero
	always_comb begin
		rdata = 8'h00;
		if (hit(idx_q, `ADCC_IDX_PORT_A_LEVELS))
			rdata = {2'b00, i_port_a_pin_levels & ~analog_mask(pin_cfg_q)};
		else if (hit(idx_q, `ADCC_IDX_CORE_IRQ_LO) || hit(idx_q, `ADCC_IDX_CORE_IRQ_HI))
			rdata = {core_irq_q, 6'h00};
		else if (hit(idx_q, `ADCC_IDX_IRQ_FLAGS))
			rdata = {1'b0, cc_flag_q, 6'h00};
		else if (hit(idx_q, `ADCC_IDX_RESULT))
			rdata = result;
		else if (hit(idx_q, `ADCC_IDX_CONV_CTRL))
			rdata = {ctrl_q[7:2], 1'b0, ctrl_q[0]};
		else if (hit(idx_q, `ADCC_IDX_PORT_A_DIR))
			rdata = {2'b00, dir_q};
		else if (hit(idx_q, `ADCC_IDX_IRQ_ENABLES))
			rdata = {1'b0, cc_enable_q, 6'h00};
		else if (hit(idx_q, `ADCC_IDX_PIN_CONFIG))
			rdata = {5'h00, pin_cfg_q};
	end

	// Read data register, zero for unmapped addresses
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst)
			o_hrdata <= 32'h00000000;
		else if (pend_q && !wr_q)
			o_hrdata <= {24'h000000, mapped_q ? rdata : 8'h00};
	end

	////////////////////////////////////////////////////////////////////////
	// Converter control register and start logic
	assign go_q      = ctrl_q[`ADCC_CTRL_GO_BIT];
	assign power_q   = ctrl_q[`ADCC_CTRL_POWER_BIT];
	assign trig_mode = i_compare_unit_mode_field == `ADCC_TRIG_MODE;
	assign trig_ok   = i_special_event_trigger && trig_mode && power_q;
	assign sar_start = go_q && !sar_busy && !sar_done; // Go still reads 1 in the done cycle
	assign sar_abort = sar_busy && !go_q;

	// Go sets by software or trigger, clears at completion, on a write with Go or power at zero, or on warm reset
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			ctrl_q <= `ADCC_CTRL_RESET;
		end else if (i_warm_rst) begin
			ctrl_q <= `ADCC_CTRL_RESET;
		end else begin
			if (wr_en && hit(idx_q, `ADCC_IDX_CONV_CTRL)) begin
				ctrl_q[7:3] <= wdata[7:3];
				ctrl_q[1]   <= 1'b0;
				ctrl_q[`ADCC_CTRL_POWER_BIT] <= wdata[`ADCC_CTRL_POWER_BIT];
				ctrl_q[`ADCC_CTRL_GO_BIT]    <= wdata[`ADCC_CTRL_GO_BIT] &&
					wdata[`ADCC_CTRL_POWER_BIT];
			end
			if (sar_done)
				ctrl_q[`ADCC_CTRL_GO_BIT] <= 1'b0;
			if (trig_ok && !go_q)
				ctrl_q[`ADCC_CTRL_GO_BIT] <= 1'b1;
		end
	end

	// Timer clear follows every special event trigger while the mode field selects the trigger mode, powered or not
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst)
			o_timer_clear <= 1'b0;
		else
			o_timer_clear <= i_special_event_trigger && trig_mode;
	end

	////////////////////////////////////////////////////////////////////////
	// Configuration, direction and port latch registers
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			pin_cfg_q  <= `ADCC_PIN_CFG_RESET;
			dir_q      <= `ADCC_PORT_A_DIR_RESET;
			port_out_q <= 6'h00;
		end else if (i_warm_rst) begin
			pin_cfg_q  <= `ADCC_PIN_CFG_RESET;
			dir_q      <= `ADCC_PORT_A_DIR_RESET;
		end else if (wr_en) begin
			if (hit(idx_q, `ADCC_IDX_PIN_CONFIG))
				pin_cfg_q <= wdata[2:0];
			if (hit(idx_q, `ADCC_IDX_PORT_A_DIR))
				dir_q <= wdata[5:0];
			if (hit(idx_q, `ADCC_IDX_PORT_A_LEVELS))
				port_out_q <= wdata[5:0];
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Interrupt enables
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			cc_enable_q <= 1'b0;
			core_irq_q  <= 2'b00;
		end else if (i_warm_rst) begin
			cc_enable_q <= 1'b0;
			core_irq_q  <= 2'b00;
		end else if (wr_en) begin
			if (hit(idx_q, `ADCC_IDX_IRQ_ENABLES))
				cc_enable_q <= wdata[`ADCC_CC_FLAG_BIT];
			if (hit(idx_q, `ADCC_IDX_CORE_IRQ_LO) || hit(idx_q, `ADCC_IDX_CORE_IRQ_HI))
				core_irq_q <= {wdata[`ADCC_GLOBAL_EN_BIT], wdata[`ADCC_PERIPH_EN_BIT]};
		end
	end

	// Completion flag: set by completion, cleared by a read or warm reset, set wins
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst)
			cc_flag_q <= 1'b0;
		else if (sar_done)
			cc_flag_q <= 1'b1;
		else if (i_warm_rst)
			cc_flag_q <= 1'b0;
		else if (rd_en && hit(idx_q, `ADCC_IDX_IRQ_FLAGS))
			cc_flag_q <= 1'b0;
	end

	// Level interrupt gated by enable and both core enables
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst)
			o_irq <= 1'b0;
		else
			o_irq <= cc_flag_q && cc_enable_q && core_irq_q[0] && core_irq_q[1];
	end

	////////////////////////////////////////////////////////////////////////
	// Conversion timing and sequencer
	adcc_tad_gen u_tad (
		.i_mclk         (i_mclk),
		.i_rst          (i_rst),
		.i_run          (sar_busy),
		.i_clk_sel      (adcc_clk_sel_t'(ctrl_q[7:6])),
		.i_rc_half_tick (i_rc_half_tick),
		.o_half_tick    (half_tick)
	);

	adcc_sar u_sar (
		.i_mclk       (i_mclk),
		.i_rst        (i_rst),
		.i_start      (sar_start),
		.i_abort      (sar_abort),
		.i_half_tick  (half_tick),
		.i_cmp_high   (i_cmp_high),
		.o_busy       (sar_busy),
		.o_done       (sar_done),
		.o_trial_code (o_trial_code),
		.o_result     (result)
	);

	// Outputs taken straight from registers
	assign o_hold_sample          = sar_busy;
	assign o_input_channel_select = ctrl_q[5:3];
	assign o_converter_power      = power_q;
	assign o_pin_analog_config    = pin_cfg_q;
	assign o_port_a_direction     = dir_q;
	assign o_port_a_out           = port_out_q;

	////////////////////////////////////////////////////////////////////////
	// Checks
	logic ctrl_wr;
	assign ctrl_wr = wr_en && hit(idx_q, `ADCC_IDX_CONV_CTRL);

	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_rst);

	sequence trig_seen;
		i_special_event_trigger && trig_mode;
	endsequence

	sequence done_effects;
		!go_q && cc_flag_q && !sar_busy;
	endsequence

	chk_trig_start: assert property (
		(trig_seen and (power_q && !go_q && !i_warm_rst)) |=> go_q ##1 sar_busy
	) else $error("accepted trigger did not start a conversion");

	chk_trig_unpowered: assert property (
		(trig_seen and (!power_q && !go_q && !ctrl_wr)) |=> !go_q
	) else $error("trigger started an unpowered converter");

	chk_mode_gate: assert property (
		(i_special_event_trigger && !trig_mode && !go_q && !ctrl_wr) |=> !go_q && !o_timer_clear
	) else $error("trigger acted outside special event mode");

	chk_timer_clear: assert property (
		trig_seen |=> o_timer_clear
	) else $error("timer not cleared by trigger");

	chk_done_effects: assert property (
		(sar_done && !i_warm_rst) |=> done_effects
	) else $error("completion effects missing");

	chk_no_restart: assert property (
		(trig_seen and (sar_busy && go_q && !half_tick && !ctrl_wr && !i_warm_rst)) |=>
			sar_busy && $stable(o_trial_code)
	) else $error("trigger disturbed a running conversion");

	chk_warm_reset: assert property (
		i_warm_rst |=> ctrl_q == `ADCC_CTRL_RESET && pin_cfg_q == `ADCC_PIN_CFG_RESET &&
			dir_q == `ADCC_PORT_A_DIR_RESET && core_irq_q == 2'b00 && !cc_enable_q
	) else $error("warm reset left control state");

	chk_result_kept: assert property (
		(i_warm_rst && !sar_busy) |=> $stable(result)
	) else $error("result changed on warm reset");

	chk_irq_level: assert property (
		(cc_flag_q && cc_enable_q && core_irq_q == 2'b11) |=> o_irq
	) else $error("interrupt not raised for enabled completion");

	chk_bus_answer: assert property (
		acc |=> !o_hreadyout ##1 o_hreadyout
	) else $error("bus answer not after one wait state");

endmodule

// [adcc_defines.svh]
// Offsets, field positions, reset values and timing counts of the converter control block.
// Assumes a byte-addressed AHB-Lite bus; register index times four is the byte address.
`ifndef ADCC_DEFINES_SVH
`define ADCC_DEFINES_SVH

////////////////////////////////////////////////////////////////////////////////
// Register indices (byte address is index * 4)
`define ADCC_IDX_PORT_A_LEVELS    8'h05
`define ADCC_IDX_CORE_IRQ_LO      8'h0b
`define ADCC_IDX_IRQ_FLAGS        8'h0c
`define ADCC_IDX_RESULT           8'h1e
`define ADCC_IDX_CONV_CTRL        8'h1f
`define ADCC_IDX_PORT_A_DIR       8'h85
`define ADCC_IDX_CORE_IRQ_HI      8'h8b
`define ADCC_IDX_IRQ_ENABLES      8'h8c
`define ADCC_IDX_PIN_CONFIG       8'h9f

////////////////////////////////////////////////////////////////////////////////
// Field positions
`define ADCC_CTRL_CLKSEL_LSB      6
`define ADCC_CTRL_CHAN_LSB        3
`define ADCC_CTRL_GO_BIT          2
`define ADCC_CTRL_POWER_BIT       0
`define ADCC_CC_FLAG_BIT          6
`define ADCC_GLOBAL_EN_BIT        7
`define ADCC_PERIPH_EN_BIT        6

////////////////////////////////////////////////////////////////////////////////
// Reset values and encodings
`define ADCC_CTRL_RESET           8'h00
`define ADCC_PIN_CFG_RESET        3'h0
`define ADCC_PORT_A_DIR_RESET     6'h3f
`define ADCC_TRIG_MODE            4'hb

////////////////////////////////////////////////////////////////////////////////
// Half bit-period lengths in core clocks, and conversion length in half bit periods
`define ADCC_HALF_DIV2            5'd1
`define ADCC_HALF_DIV8            5'd4
`define ADCC_HALF_DIV32           5'd16
`define ADCC_SETUP_HALF_TADS      4'd3
`define ADCC_CONV_HALF_TADS       5'd19

`endif

// [adcc_pkg.sv]
// Types shared by the converter control block.
// Assumes the defines header is compiled alongside.
package adcc_pkg;

	// Conversion clock select, in register encoding order
	typedef enum logic [1:0] {
		ADCC_CLK_DIV2,
		ADCC_CLK_DIV8,
		ADCC_CLK_DIV32,
		ADCC_CLK_RC
	} adcc_clk_sel_t;

	// Successive-approximation sequencer states
	typedef enum logic [1:0] {
		ADCC_SAR_IDLE,
		ADCC_SAR_SETUP,
		ADCC_SAR_BITS
	} adcc_sar_state_t;

endpackage

// [adcc_tad_gen.sv]
// Half bit-period tick generator for the converter.
// Assumes the RC half tick input is already a single-cycle pulse in the core clock domain.
`timescale 1ns/1ps
`include "adcc_defines.svh"

module adcc_tad_gen (
	input  wire logic                  i_mclk,
	input  wire logic                  i_rst,
	input  wire logic                  i_run,
	input  wire adcc_pkg::adcc_clk_sel_t i_clk_sel,
	input  wire logic                  i_rc_half_tick,
	output logic                       o_half_tick
);
	import adcc_pkg::*;

	logic [4:0] cnt_q;

	// Core clocks per half bit period for each divided select; the RC entry is never used
	function automatic logic [4:0] half_div(input adcc_clk_sel_t sel);
		unique case (sel)
			ADCC_CLK_DIV2:  half_div = `ADCC_HALF_DIV2;
			ADCC_CLK_DIV8:  half_div = `ADCC_HALF_DIV8;
			ADCC_CLK_DIV32: half_div = `ADCC_HALF_DIV32;
			ADCC_CLK_RC:    half_div = `ADCC_HALF_DIV2;
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Divider, restarted whenever no conversion runs
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			cnt_q       <= 5'd0;
			o_half_tick <= 1'b0;
		end else if (!i_run) begin
			cnt_q       <= 5'd0;
			o_half_tick <= 1'b0;
		end else if (i_clk_sel == ADCC_CLK_RC) begin
			cnt_q       <= 5'd0;
			o_half_tick <= i_rc_half_tick;
		end else if (cnt_q == half_div(i_clk_sel) - 5'd1) begin
			cnt_q       <= 5'd0;
			o_half_tick <= 1'b1;
		end else begin
			cnt_q       <= cnt_q + 5'd1;
			o_half_tick <= 1'b0;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_rst || !i_run);

	chk_div8_period: assert property (
		(o_half_tick && i_clk_sel == ADCC_CLK_DIV8) |=> (!o_half_tick)[*3] ##1 o_half_tick
	) else $error("half tick spacing wrong for divide by eight");

	chk_div2_period: assert property (
		(o_half_tick && i_clk_sel == ADCC_CLK_DIV2 && $past(i_clk_sel) == ADCC_CLK_DIV2)
			|=> o_half_tick
	) else $error("half tick spacing wrong for divide by two");

endmodule

// [adcc_sar.sv]
// Successive-approximation sequencer: 1.5 bit periods of setup, then eight bits.
// Assumes the analog core compares its held input against the trial code each cycle.
`timescale 1ns/1ps
`include "adcc_defines.svh"

module adcc_sar (
	input  wire logic  i_mclk,
	input  wire logic  i_rst,
	input  wire logic  i_start,
	input  wire logic  i_abort,
	input  wire logic  i_half_tick,
	input  wire logic  i_cmp_high,
	output logic       o_busy,
	output logic       o_done,
	output logic [7:0] o_trial_code,
	output logic [7:0] o_result
);
	import adcc_pkg::*;

	adcc_sar_state_t state_q;
	logic [3:0]      hcnt_q;
	logic [2:0]      bit_pos;
	logic            decide;
	logic            last_bit;
	logic [7:0]      trial_d;

	// Drop the bit under test if input is below trial, then try the next lower bit
	function automatic logic [7:0] sar_step(input logic [7:0] trial, input logic [2:0] pos,
		input logic keep);
		logic [7:0] t;
		t = trial;
		t[pos] = keep;
		if (pos != 3'd0)
			t[pos - 3'd1] = 1'b1;
		sar_step = t;
	endfunction

	// Bit decided on every second half tick of the bit phase
	assign bit_pos  = 3'd7 - hcnt_q[3:1];
	assign decide   = (state_q == ADCC_SAR_BITS) && i_half_tick && hcnt_q[0] && !i_abort;
	assign last_bit = bit_pos == 3'd0;
	assign trial_d  = sar_step(o_trial_code, bit_pos, i_cmp_high);

	////////////////////////////////////////////////////////////////////////
	// Sequencer
	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst) begin
			state_q      <= ADCC_SAR_IDLE;
			hcnt_q       <= 4'd0;
			o_busy       <= 1'b0;
			o_done       <= 1'b0;
			o_trial_code <= 8'h00;
		end else begin
			o_done <= 1'b0;
			unique case (state_q)
				ADCC_SAR_IDLE: begin
					if (i_start) begin
						state_q      <= ADCC_SAR_SETUP;
						hcnt_q       <= 4'd0;
						o_busy       <= 1'b1;
						o_trial_code <= 8'h00;
					end
				end
				ADCC_SAR_SETUP: begin
					if (i_abort) begin
						state_q <= ADCC_SAR_IDLE;
						o_busy  <= 1'b0;
					end else if (i_half_tick) begin
						if (hcnt_q == `ADCC_SETUP_HALF_TADS - 4'd1) begin
							state_q      <= ADCC_SAR_BITS;
							hcnt_q       <= 4'd0;
							o_trial_code <= 8'h80;
						end else begin
							hcnt_q <= hcnt_q + 4'd1;
						end
					end
				end
				ADCC_SAR_BITS: begin
					if (i_abort) begin
						state_q <= ADCC_SAR_IDLE;
						o_busy  <= 1'b0;
					end else if (i_half_tick) begin
						hcnt_q <= hcnt_q + 4'd1;
						if (decide) begin
							o_trial_code <= trial_d;
						end
						if (decide && last_bit) begin
							state_q <= ADCC_SAR_IDLE;
							o_busy  <= 1'b0;
							o_done  <= 1'b1;
						end
					end
				end
			endcase
		end
	end

	// Result holds through every reset; unknown until the first conversion
	always_ff @(posedge i_mclk) begin
		if (decide && last_bit)
			o_result <= trial_d;
	end

	////////////////////////////////////////////////////////////////////////
	// Checks: count half ticks seen by one conversion
	logic [4:0] seen_q;

	always_ff @(posedge i_mclk or posedge i_rst) begin
		if (i_rst)
			seen_q <= 5'd0;
		else if (i_start && !o_busy)
			seen_q <= 5'd0;
		else if (o_busy && i_half_tick)
			seen_q <= seen_q + 5'd1;
	end

	default clocking cb @(posedge i_mclk);
	endclocking
	default disable iff (i_rst);

	chk_conv_length: assert property (
		o_done |-> seen_q == `ADCC_CONV_HALF_TADS
	) else $error("conversion did not take nine and a half bit periods");

endmodule

// [adcc_far_model.sv]
// Far side model: trigger source of the capture/compare unit and analog comparator.
// Assumes the core clock drives it and the trial code comes from the converter.
`timescale 1ns/1ps

module adcc_far_model #(
	parameter logic [7:0] LEVEL = 8'h5a
) (
	input  wire logic       i_mclk,
	input  wire logic       i_fire,
	input  wire logic [7:0] i_trial_code,
	output logic            o_trigger,
	output logic            o_cmp_high,
	output logic            o_rc_half_tick
);
	logic [2:0] rc_q = 3'h0;

	// Comparator: held input at or above the trial code
	assign o_cmp_high = (LEVEL >= i_trial_code);

	// Trigger as one pulse per request, one core clock after the request
	always_ff @(posedge i_mclk) begin
		o_trigger <= i_fire;
	end

	// Internal RC clock: a half tick every five core clocks
	always_ff @(posedge i_mclk) begin
		rc_q <= (rc_q == 3'h4) ? 3'h0 : rc_q + 3'h1;
		o_rc_half_tick <= (rc_q == 3'h4);
	end
endmodule

// [adcc_tb_top.sv]
// Testbench: register bus, conversions, trigger, interrupt and warm reset.
// Assumes adcc_top and the far side model are compiled before it.
`timescale 1ns/1ps

module adcc_tb_top;
	logic        i_mclk = 1'b0;
	logic        i_rst  = 1'b1;
	logic        warm   = 1'b0;
	logic        hsel   = 1'b0;
	logic [31:0] haddr  = 32'h0;
	logic [1:0]  htrans = 2'h0;
	logic        hwrite = 1'b0;
	logic [31:0] hwdata = 32'h0;
	logic [3:0]  mode   = 4'h0;
	logic        fire   = 1'b0;
	logic        hrdy, trig, cmp, rck, tclr, hold, irq, pwr, hresp;
	logic [2:0]  chan, pcfg;
	logic [5:0]  pdir, pout;
	logic [31:0] hrdata, rv;
	logic [7:0]  trial;
	int          err_total = 0;
	int          cmp_count = 0;
	int          hcnt = 0;
	int          tcnt = 0;
	int          cyc = 0;
	int          half[3] = '{1, 4, 16};

	adcc_top uut (
		.i_mclk(i_mclk), .i_rst(i_rst), .i_warm_rst(warm), .i_hsel(hsel),
		.i_haddr(haddr), .i_htrans(htrans), .i_hwrite(hwrite), .i_hsize(3'h2),
		.i_hwdata(hwdata), .i_hready(hrdy), .o_hreadyout(hrdy), .o_hresp(hresp),
		.o_hrdata(hrdata), .i_compare_unit_mode_field(mode),
		.i_special_event_trigger(trig), .o_timer_clear(tclr), .i_cmp_high(cmp),
		.i_rc_half_tick(rck), .o_trial_code(trial), .o_hold_sample(hold),
		.o_input_channel_select(chan), .o_converter_power(pwr), .o_pin_analog_config(pcfg),
		.i_port_a_pin_levels(6'h2a), .o_port_a_direction(pdir), .o_port_a_out(pout),
		.o_irq(irq)
	);

	adcc_far_model model (
		.i_mclk(i_mclk), .i_fire(fire), .i_trial_code(trial),
		.o_trigger(trig), .o_cmp_high(cmp), .o_rc_half_tick(rck)
	);

	////////////////////////////////////////////////////////////////////////
	// Clock at 100 MHz
	initial begin
		forever #5 i_mclk = ~i_mclk;
	end

	// Count busy and timer clear cycles; cut a hang short
	always @(posedge i_mclk) begin
		hcnt += (hold === 1'b1);
		tcnt += (tclr === 1'b1);
		cyc++;
		if (cyc > 20000) begin
			err_total++;
			stop_test;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Report the counts and the verdict, then end the run
	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", cmp_count, err_total);
		if (err_total == 0 && cmp_count > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	// Compare one value
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		cmp_count++;
		if (seen !== exp) begin
			err_total++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	// One single word transfer; address is index times four
	task automatic xfer(input logic w, input logic [7:0] idx, input logic [31:0] wd);
		@(posedge i_mclk);
		hsel   <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr  <= {22'h0, idx, 2'b00};
		@(posedge i_mclk);
		while (hrdy !== 1'b1) @(posedge i_mclk);
		hsel   <= 1'b0;
		htrans <= 2'h0;
		hwdata <= wd;
		@(posedge i_mclk);
		while (hrdy !== 1'b1) @(posedge i_mclk);
		rv = hrdata;
	endtask

	// Read a register and compare
	task automatic rd(input logic [7:0] idx, input logic [31:0] exp);
		xfer(1'b0, idx, 32'h0);
		chk($sformatf("reg %h", idx), rv, exp);
	endtask

	// Wait until a started conversion has ended
	task automatic wait_done;
		@(posedge i_mclk);
		while (!(hcnt > 0 && hold === 1'b0)) @(posedge i_mclk);
		repeat (64) @(posedge i_mclk);
	endtask

	// Send one trigger request to the far side model
	task automatic shoot;
		@(posedge i_mclk);
		fire <= 1'b1;
		@(posedge i_mclk);
		fire <= 1'b0;
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		repeat (10) @(posedge i_mclk);
		i_rst <= 1'b0;
		rd(8'h1f, 32'h0);
		rd(8'h9f, 32'h0);
		rd(8'h0c, 32'h0);
		rd(8'h8c, 32'h0);
		rd(8'h0b, 32'h0);
		rd(8'h85, 32'h3f);
		rd(8'h40, 32'h0);
		rd(8'h05, 32'h0);
		chk("dir pins", pdir, 6'h3f);
		chk("bus response", hresp, 1'b0);
		xfer(1'b1, 8'h9f, 32'hff);
		rd(8'h9f, 32'h07);
		chk("pin config pins", pcfg, 3'h7);
		rd(8'h05, 32'h2a);
		xfer(1'b1, 8'h05, 32'h15);
		xfer(1'b1, 8'h85, 32'h05);
		rd(8'h85, 32'h05);
		chk("port out pins", pout, 6'h15);
		xfer(1'b1, 8'h1f, 32'hfb);
		rd(8'h1f, 32'hf9);
		chk("channel pins", chan, 3'h7);
		chk("power pin", pwr, 1'b1);
		xfer(1'b1, 8'h8c, 32'h40);
		xfer(1'b1, 8'h0b, 32'hc0);
		rd(8'h8b, 32'hc0);
		// Software starts at each clock select; busy spans 19 half periods plus the tick register
		for (int s = 0; s < 4; s++) begin
			xfer(1'b1, 8'h1f, {24'h0, s[1:0], 6'h01});
			hcnt = 0;
			xfer(1'b1, 8'h1f, {24'h0, s[1:0], 6'h05});
			wait_done;
			if (s < 3)
				chk("busy cycles", hcnt, 19 * half[s] + 1);
			else
				chk("rc busy cycles", hcnt >= 92 && hcnt <= 96, 1'b1);
			rd(8'h1f, {24'h0, s[1:0], 6'h01});
			rd(8'h1e, 32'h5a);
			chk("irq set", irq, 1'b1);
			rd(8'h0c, 32'h40);
			rd(8'h0c, 32'h0);
			chk("irq clear", irq, 1'b0);
		end
		// Accepted trigger
		mode <= 4'hb;
		xfer(1'b1, 8'h1f, 32'h01);
		hcnt = 0;
		tcnt = 0;
		shoot;
		wait_done;
		chk("timer clear", tcnt, 1);
		chk("trig busy", hcnt, 20);
		rd(8'h0c, 32'h40);
		// Wrong mode: no conversion, no timer clear
		mode <= 4'ha;
		hcnt = 0;
		tcnt = 0;
		shoot;
		repeat (30) @(posedge i_mclk);
		chk("mode timer", tcnt, 0);
		chk("mode busy", hcnt, 0);
		// Unpowered: trigger ignored but timer cleared
		mode <= 4'hb;
		xfer(1'b1, 8'h1f, 32'h00);
		shoot;
		repeat (30) @(posedge i_mclk);
		chk("off timer", tcnt, 1);
		chk("off busy", hcnt, 0);
		rd(8'h1f, 32'h0);
		// Trigger in mid conversion does not restart it
		xfer(1'b1, 8'h1f, 32'h41);
		tcnt = 0;
		xfer(1'b1, 8'h1f, 32'h45);
		repeat (20) @(posedge i_mclk);
		shoot;
		wait_done;
		chk("no restart", hcnt, 77);
		chk("busy timer", tcnt, 1);
		// Warm reset keeps the result and the port out latch
		@(posedge i_mclk);
		warm <= 1'b1;
		@(posedge i_mclk);
		warm <= 1'b0;
		rd(8'h1e, 32'h5a);
		rd(8'h1f, 32'h0);
		rd(8'h8c, 32'h0);
		rd(8'h0b, 32'h0);
		rd(8'h85, 32'h3f);
		rd(8'h0c, 32'h0);
		rd(8'h9f, 32'h0);
		chk("warm dir pins", pdir, 6'h3f);
		chk("warm port out", pout, 6'h15);
		chk("warm irq", irq, 1'b0);
		stop_test;
	end
endmodule
